// ==== src/recal_seq_regs.vh ====
// Purpose: Constants for the reset and calibration sequencer
// Assumes: 10 MHz system clock
// Notes:   Times kept in their own unit, counts derived from them
`ifndef RECAL_SEQ_REGS_VH
`define RECAL_SEQ_REGS_VH
`define CLK_FREQ_HZ        10000000
`define PIPE_LATENCY       17
`define CAL_NOM_MS         200
`define CAL_MAX_MS         550
`define CAL_NOM_CYCLES     (`CAL_NOM_MS * (`CLK_FREQ_HZ / 1000))
`define CAL_MAX_CYCLES     (`CAL_MAX_MS * (`CLK_FREQ_HZ / 1000))
`define SAMPLE_WIDTH       8
`define FULL_SCALE_CODE    8'hff
`endif

// ==== src/sample_delay_line.v ====
// Purpose: Fixed-depth delay line for samples and their flags
// Assumes: Single clock, advances every cycle
// Notes:   Depth is a parameter, default is the pipeline latency
`timescale 1ns/1ps
module sample_delay_line #(
    parameter WIDTH = 9,
    parameter DEPTH = 17
) (
    input  wire             clock,
    input  wire             reset_n,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage_reg [0:DEPTH-1];
    integer i;

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                stage_reg[i] <= {WIDTH{1'b0}};
            end
        end else begin
            stage_reg[0] <= din;
            for (i = 1; i < DEPTH; i = i + 1) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign dout = stage_reg[DEPTH-1];
endmodule // sample_delay_line

// ==== src/adc_reset_calibration_sequencer.v ====
// Purpose: Power-on and requested calibration sequencing, sample pipeline
// Assumes: All inputs synchronous to clock (the conversion clock)
// Notes:   Calibration length is a parameter so simulation can shorten it
`timescale 1ns/1ps
`include "recal_seq_regs.vh"

// How it works
// - Each sample leaves the output exactly 17 clock cycles after it enters.
// - The two cores take samples on alternate cycles, doubling the rate.
// - Once both supply-good levels are high, power-on calibration starts.
// - After supplies settle the detector stops pulling the request line low.
// - Calibration begins on the rising edge of the active-low request.
// - Over-range is high from the request going low until calibration ends.
// - An over-range input at calibration end keeps the flag high.
// - The sample clock output is held low while the request is low.
// - The sample clock resumes toggling on the first edge after release.
// - Calibration takes the nominal time and never beyond the maximum.
// - Over-range follows positive full scale, refreshed once per sample.
module adc_reset_calibration_sequencer #(
    parameter CAL_CYCLES = `CAL_NOM_CYCLES,
    parameter LATENCY    = `PIPE_LATENCY
) (
    input  wire       clock,
    input  wire       reset_n,
    input  wire       analog_supply_ok,
    input  wire       digital_supply_ok,
    input  wire       recal_request_low_in,
    output reg        recal_request_low_out,
    output reg        recal_request_low_oe,
    input  wire [7:0] core_a_sample,
    input  wire [7:0] core_b_sample,
    output reg  [7:0] sample_data_out,
    output reg        over_range,
    output reg        sample_clock_out,
    output reg        calibrating,
    output reg        core_a_strobe,
    output reg        core_b_strobe
);
    localparam ST_POWER_UP = 2'd0;
    localparam ST_HELD     = 2'd1;
    localparam ST_CAL      = 2'd2;
    localparam ST_RUN      = 2'd3;
    localparam [31:0] CAL_LAST = CAL_CYCLES - 1;
    localparam [31:0] CAL_LIMIT = `CAL_MAX_CYCLES - 1;
    // Never stretch calibration past its longest time, whatever the setting
    localparam [31:0] CAL_END_COUNT =
        (CAL_LAST < CAL_LIMIT) ? CAL_LAST : CAL_LIMIT;

    reg  [1:0]  state_reg;
    reg  [1:0]  state_next;
    reg  [31:0] cal_count_reg;
    reg         request_prev_reg;
    reg         core_sel_reg;
    reg  [7:0]  picked_sample;
    wire [8:0]  delayed;
    wire        supplies_ok;
    wire        request_rise;
    wire        cal_done;
    wire        cal_running;
    wire        hold_flag;
    wire        at_full_scale;
    wire [8:0]  pipe_in;
    wire [7:0]  delayed_code;
    wire        delayed_full;

    assign supplies_ok  = analog_supply_ok & digital_supply_ok;
    // Edge seen on clock samples only; a one-cycle low is enough
    assign request_rise = recal_request_low_in & ~request_prev_reg;
    assign cal_done     = (state_reg == ST_CAL) &&
                          (cal_count_reg == CAL_END_COUNT);
    assign cal_running  = (state_next == ST_CAL) && (state_reg == ST_CAL);
    // Flag is forced while the line is low or calibration is unfinished
    assign hold_flag    = !recal_request_low_in || (state_next != ST_RUN);

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_POWER_UP: begin
                if (supplies_ok) begin
                    state_next = ST_HELD;
                end
            end
            ST_HELD: begin
                if (request_rise) begin
                    state_next = ST_CAL;
                end
            end
            ST_CAL: begin
                // A new low aborts and restarts on its release
                if (!recal_request_low_in) begin
                    state_next = ST_HELD;
                end else if (cal_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!recal_request_low_in) begin
                    state_next = ST_HELD;
                end
            end
            default: state_next = ST_POWER_UP;
        endcase
    end

    // Line is held low after reset, so a zero here gives no false edge
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg        <= ST_POWER_UP;
            request_prev_reg <= 1'b0;
        end else begin
            state_reg        <= state_next;
            request_prev_reg <= recal_request_low_in;
        end
    end

    // Counter only runs while staying in calibration; any exit clears it
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cal_count_reg <= 32'h0000_0000;
        end else if (cal_running) begin
            cal_count_reg <= cal_count_reg + 32'h0000_0001;
        end else begin
            cal_count_reg <= 32'h0000_0000;
        end
    end

    // Data side of the open-drain line is always low; only the enable moves
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            recal_request_low_out <= 1'b0;
        end else begin
            recal_request_low_out <= 1'b0;
        end
    end

    // Line driven low until supplies are good, then released to pull-up
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            recal_request_low_oe <= 1'b1;
        end else begin
            recal_request_low_oe <= (state_next == ST_POWER_UP);
        end
    end

    // Alternate cores each cycle
    always @* begin
        picked_sample = core_sel_reg ? core_b_sample : core_a_sample;
    end

    // Over-range bit rides the pipeline beside its own code
    assign at_full_scale = (picked_sample == `FULL_SCALE_CODE);
    assign pipe_in       = {at_full_scale, picked_sample};

    sample_delay_line #(
        .WIDTH (9),
        .DEPTH (LATENCY - 1)
    ) u_pipe (
        .clock   (clock),
        .reset_n (reset_n),
        .din     (pipe_in),
        .dout    (delayed)
    );

    assign delayed_code = delayed[7:0];
    assign delayed_full = delayed[8];

    // Select flips every cycle; strobe tells a core it was taken
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            core_sel_reg  <= 1'b0;
            core_a_strobe <= 1'b0;
            core_b_strobe <= 1'b0;
        end else begin
            core_sel_reg  <= ~core_sel_reg;
            core_a_strobe <= ~core_sel_reg;
            core_b_strobe <= core_sel_reg;
        end
    end

    // Output register is the last pipeline stage: 17 total
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sample_data_out <= 8'h00;
        end else begin
            sample_data_out <= delayed_code;
        end
    end

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            calibrating <= 1'b1;
        end else begin
            calibrating <= (state_next != ST_RUN);
        end
    end

    // Forced high while held, so it cannot fall before calibration ends
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            over_range <= 1'b1;
        end else if (hold_flag) begin
            over_range <= 1'b1;
        end else begin
            // Full scale code saturates, flag per sample
            over_range <= delayed_full;
        end
    end

    // Stopped at once on a request, so no short pulse reaches the host
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sample_clock_out <= 1'b0;
        end else if (!recal_request_low_in) begin
            sample_clock_out <= 1'b0;
        end else begin
            sample_clock_out <= ~sample_clock_out;
        end
    end
endmodule // adc_reset_calibration_sequencer

// ==== verif/adc_reset_calibration_sequencer_properties.sv ====
// Purpose: Port checks for the calibration sequencer
// Assumes: Line input is the resolved level
// Notes:   Bound to every instance
`timescale 1ns/1ps
module recal_seq_checker #(
    parameter int CAL_CYCLES = 20
) (
    input wire       clock,
    input wire       reset_n,
    input wire       analog_supply_ok,
    input wire       digital_supply_ok,
    input wire       recal_request_low_in,
    input wire       recal_request_low_oe,
    input wire [7:0] sample_data_out,
    input wire       over_range,
    input wire       sample_clock_out,
    input wire       calibrating,
    input wire       core_a_strobe,
    input wire       core_b_strobe
);
    localparam int CAL_END = CAL_CYCLES;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_low_sets_flag: assert property (
        !recal_request_low_in |=> over_range) else $error("flag low");
    a_low_stops_clk: assert property (
        !recal_request_low_in |=> !sample_clock_out) else $error("clk out");
    a_clock_resumes: assert property (
        recal_request_low_in
        |=> sample_clock_out != $past(sample_clock_out)) else $error("toggle");
    a_cal_length: assert property (
        $rose(recal_request_low_in)
        |-> ##CAL_END calibrating ##1 !calibrating) else $error("cal length");
    a_flag_in_cal: assert property (
        calibrating |-> over_range) else $error("flag in cal");
    a_flag_follows: assert property (
        !calibrating && $past(recal_request_low_in)
        |-> over_range == (sample_data_out == 8'hff)) else $error("flag");
    a_core_a_alt: assert property (
        core_a_strobe |-> !core_b_strobe ##1 !core_a_strobe) else $error("a");
    a_core_b_alt: assert property (
        core_b_strobe |=> !core_b_strobe) else $error("b");
    a_oe_release: assert property (
        analog_supply_ok && digital_supply_ok |=> !recal_request_low_oe)
        else $error("oe held");
endmodule // recal_seq_checker
bind adc_reset_calibration_sequencer recal_seq_checker #(
    .CAL_CYCLES(CAL_CYCLES)) u_chk (.clock, .reset_n, .analog_supply_ok,
    .digital_supply_ok, .recal_request_low_in, .recal_request_low_oe,
    .sample_data_out, .over_range, .sample_clock_out, .calibrating,
    .core_a_strobe, .core_b_strobe);

// ==== verif/recal_host_model.sv ====
// Purpose: Host side of the open-drain recalibration line
// Assumes: Pull-up on the line, parties only pull low
// Notes:   Never floats, so no unknown reaches the device
`timescale 1ns/1ps
module recal_host_model (
    input  wire pull_low,
    input  wire dev_out,
    input  wire dev_oe,
    output wire line
);
    // Pull-up wins unless someone pulls low
    assign line = !pull_low && !(dev_oe && !dev_out);
endmodule // recal_host_model

// ==== verif/test_adc_reset_calibration_sequencer.sv ====
// Purpose: Self-checking bench for the calibration sequencer
// Assumes: Calibration shortened to CAL cycles
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
module test_adc_reset_calibration_sequencer;
    localparam int CAL = 20;
    reg        clock = 1'b0;
    reg        reset_n = 1'b0;
    reg        supply = 1'b0;
    reg        pull_low = 1'b1;
    reg  [7:0] sample = 8'h00;
    reg  [7:0] skew = 8'h00;
    wire [7:0] data;
    wire       line, d_out, d_oe, ovr, clk_out, cal;
    int        errors = 0, n_checks = 0, cycles = 0, n;
    initial begin
        forever #50 clock = ~clock; // Single rate only
    end
    adc_reset_calibration_sequencer #(.CAL_CYCLES(CAL)) DUT (
        .clock(clock), .reset_n(reset_n), .analog_supply_ok(supply),
        .digital_supply_ok(supply), .recal_request_low_in(line),
        .recal_request_low_out(d_out), .recal_request_low_oe(d_oe),
        .core_a_sample(sample), .core_b_sample(sample ^ skew),
        .sample_data_out(data), .over_range(ovr), .sample_clock_out(clk_out),
        .calibrating(cal), .core_a_strobe(), .core_b_strobe());
    recal_host_model host (.pull_low(pull_low), .dev_out(d_out),
        .dev_oe(d_oe), .line(line));
    task chk(input string what, input [7:0] exp, input [7:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wait_cal;
        n = 0;
        do begin
            @(negedge clock);
            n = n + 1;
        end while (cal !== 1'b0 && n < 100);
    endtask
    task t_power_up;
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        chk("flag held", 8'h01, {7'h00, ovr});
        supply = 1'b1;
        pull_low = 1'b0;
        wait_cal;
        chk("power-up length", 8'(CAL + 2), 8'(n));
        $display("power-up test done");
    endtask
    task t_recal;
        sample = 8'hff;
        @(negedge clock);
        pull_low = 1'b1;
        @(negedge clock);
        chk("flag on request", 8'h01, {7'h00, ovr});
        chk("clock held", 8'h00, {7'h00, clk_out});
        pull_low = 1'b0;
        wait_cal;
        chk("recal length", 8'(CAL + 1), 8'(n));
        chk("flag kept", 8'h01, {7'h00, ovr});
        sample = 8'h5a;
        repeat (16) @(negedge clock);
        chk("data early", 8'hff, data);
        @(negedge clock);
        chk("data latency", 8'h5a, data);
        chk("flag normal", 8'h00, {7'h00, ovr});
        $display("recal test done");
    endtask
    task t_cores;
        reg [7:0] first;
        reg [7:0] second;
        sample = 8'h11;
        skew = 8'h33;
        repeat (17) @(negedge clock);
        first = data;
        chk("core pick", 8'h01,
            {7'h00, (first == 8'h11) || (first == 8'h22)});
        @(negedge clock);
        second = data;
        chk("core mix", 8'h33, first ^ second);
        @(negedge clock);
        chk("core mix again", 8'h33, second ^ data);
        skew = 8'h00;
        $display("core test done");
    endtask
    task t_reset;
        reset_n = 1'b0;
        @(negedge clock);
        chk("reset flag", 8'h01, {7'h00, ovr});
        chk("reset cal", 8'h01, {7'h00, cal});
        chk("reset clock", 8'h00, {7'h00, clk_out});
        reset_n = 1'b1;
        wait_cal;
        chk("restart length", 8'(CAL + 2), 8'(n));
        $display("reset test done");
    endtask
    task results;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 1000) begin
            errors = errors + 1;
            results;
        end
    end
    initial begin
        t_power_up;
        t_recal;
        t_cores;
        t_reset;
        results;
    end
endmodule // test_adc_reset_calibration_sequencer
